// ===== tla_defs.svh
// Command codes, reset values and unit constants of the alert limit bank
`ifndef TLA_DEFS_SVH
`define TLA_DEFS_SVH

`define TLA_CMD_BAT_LOW 8'h01
`define TLA_CMD_BAT_HIGH 8'h02
`define TLA_CMD_IN_LOW 8'h03
`define TLA_LIMIT_RESET 16'h0000
`define TLA_FLAG_BAT_LOW 0
`define TLA_FLAG_BAT_HIGH 1
`define TLA_FLAG_IN_LOW 2
`define TLA_BAT_LSB_NV 384800
`define TLA_IN_LSB_NV 1649000
`define TLA_CELL_VOLTS 6

`endif

// ===== tla_pkg.sv
// Types shared by the alert limit bank
package tla_pkg;

  typedef logic signed [15:0] tla_value_t;

  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] cmd;
    logic [15:0] wdata;
  } tla_reg_req_s;

  typedef struct packed {
    logic bat_valid;
    tla_value_t bat;
    logic in_valid;
    tla_value_t vin;
  } tla_conv_s;

endpackage : tla_pkg

// ===== tla_limit_check.sv
// One signed limit compare with a sticky alert flag
`timescale 1ns/1ps
module tla_limit_check #(
  parameter bit BELOW = 1'b1
) (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic resetn,
  // Sample and limit
  input wire logic sample_valid,
  input wire tla_pkg::tla_value_t sample,
  input wire tla_pkg::tla_value_t limit,
  input wire logic check_on,
  // Flag
  input wire logic clear,
  output logic flag
);

  logic hit;

  // Signed compare on each fresh result
  assign hit = sample_valid && check_on &&
               (BELOW ? (sample < limit) : (sample > limit));

  // Sticky; a crossing in the clear cycle wins over the clear
  always_ff @(posedge ref_clk or negedge resetn)
  begin
    if (!resetn)
      flag <= 1'b0;
    else
      flag <= hit | (flag & ~clear);
  end

endmodule : tla_limit_check

// ===== tla_alert_limits.sv
// Battery and input voltage alert limit registers with sticky alert flags
`timescale 1ns/1ps
`include "tla_defs.svh"

module tla_alert_limits (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic resetn,
  // Register access from the serial management decoder
  input wire tla_pkg::tla_reg_req_s reg_req,
  output logic [15:0] rd_data,
  output logic rd_ack,
  output logic cmd_hit,
  // Converter results
  input wire tla_pkg::tla_conv_s conv,
  // Alert enables
  input wire logic battery_low_check_on,
  input wire logic battery_high_check_on,
  input wire logic input_low_check_on,
  // Alert flags and their clear strobes
  input wire logic [2:0] flag_clear,
  output logic battery_low_flag,
  output logic battery_high_flag,
  output logic input_low_flag,
  // Cell count pins and scaled battery voltage
  input wire logic cell_count_sel_lo,
  input wire logic cell_count_sel_hi,
  output logic signed [18:0] battery_total
);

  tla_pkg::tla_value_t battery_low_threshold;
  tla_pkg::tla_value_t battery_high_threshold;
  tla_pkg::tla_value_t input_low_threshold;
  logic [1:0] cell_meta;
  logic [1:0] cell_sync;
  logic signed [3:0] cell_mult;
  logic [15:0] next_rd_data;
  logic known_cmd;

  // Limit registers written by command code
  always_ff @(posedge ref_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      battery_low_threshold <= `TLA_LIMIT_RESET;
      battery_high_threshold <= `TLA_LIMIT_RESET;
      input_low_threshold <= `TLA_LIMIT_RESET;
    end
    else if (reg_req.wr)
    begin
      unique case (reg_req.cmd)
        `TLA_CMD_BAT_LOW: battery_low_threshold <= reg_req.wdata;
        `TLA_CMD_BAT_HIGH: battery_high_threshold <= reg_req.wdata;
        `TLA_CMD_IN_LOW: input_low_threshold <= reg_req.wdata;
        default: ;
      endcase
    end
  end

  // Read decode; unknown codes answer zero
  always_comb
  begin
    known_cmd = 1'b1;
    unique case (reg_req.cmd)
      `TLA_CMD_BAT_LOW: next_rd_data = battery_low_threshold;
      `TLA_CMD_BAT_HIGH: next_rd_data = battery_high_threshold;
      `TLA_CMD_IN_LOW: next_rd_data = input_low_threshold;
      default:
      begin
        next_rd_data = 16'h0000;
        known_cmd = 1'b0;
      end
    endcase
  end

  always_ff @(posedge ref_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      rd_data <= 16'h0000;
      rd_ack <= 1'b0;
      cmd_hit <= 1'b0;
    end
    else
    begin
      rd_ack <= reg_req.rd;
      cmd_hit <= (reg_req.rd | reg_req.wr) & known_cmd;
      if (reg_req.rd)
        rd_data <= next_rd_data;
    end
  end

  // Battery limits compare against the raw battery result
  tla_limit_check #(
    .BELOW(1'b1)
  ) u_bat_low (
    .ref_clk(ref_clk),
    .resetn(resetn),
    .sample_valid(conv.bat_valid),
    .sample(conv.bat),
    .limit(battery_low_threshold),
    .check_on(battery_low_check_on),
    .clear(flag_clear[`TLA_FLAG_BAT_LOW]),
    .flag(battery_low_flag)
  );

  // Upper battery limit
  tla_limit_check #(
    .BELOW(1'b0)
  ) u_bat_high (
    .ref_clk(ref_clk),
    .resetn(resetn),
    .sample_valid(conv.bat_valid),
    .sample(conv.bat),
    .limit(battery_high_threshold),
    .check_on(battery_high_check_on),
    .clear(flag_clear[`TLA_FLAG_BAT_HIGH]),
    .flag(battery_high_flag)
  );

  // Input voltage lower limit
  tla_limit_check #(
    .BELOW(1'b1)
  ) u_in_low (
    .ref_clk(ref_clk),
    .resetn(resetn),
    .sample_valid(conv.in_valid),
    .sample(conv.vin),
    .limit(input_low_threshold),
    .check_on(input_low_check_on),
    .clear(flag_clear[`TLA_FLAG_IN_LOW]),
    .flag(input_low_flag)
  );

  // Cell count pins pass two flip-flops
  always_ff @(posedge ref_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      cell_meta <= 2'b00;
      cell_sync <= 2'b00;
    end
    else
    begin
      cell_meta <= {cell_count_sel_hi, cell_count_sel_lo};
      cell_sync <= cell_meta;
    end
  end

  assign cell_mult = $signed({2'b00, cell_sync}) + 4'sd1;

  // Total battery voltage, one to four cell multiples
  always_ff @(posedge ref_clk or negedge resetn)
  begin
    if (!resetn)
      battery_total <= 19'sd0;
    else if (conv.bat_valid)
      battery_total <= 19'(conv.bat * cell_mult);
  end

  // Crossing below the battery low limit sets the flag next edge
  bat_low_set_a: assert property (@(posedge ref_clk) disable iff (!resetn)
    conv.bat_valid && battery_low_check_on && (conv.bat < battery_low_threshold)
    |=> battery_low_flag)
    else $error("battery low flag not raised");

  bat_high_set_a: assert property (@(posedge ref_clk) disable iff (!resetn)
    conv.bat_valid && battery_high_check_on && (conv.bat > battery_high_threshold)
    |=> battery_high_flag)
    else $error("battery high flag not raised");

  in_low_set_a: assert property (@(posedge ref_clk) disable iff (!resetn)
    conv.in_valid && input_low_check_on && (conv.vin < input_low_threshold)
    |=> input_low_flag)
    else $error("input low flag not raised");

  // Flag rises only after a valid battery result with the low check on
  bat_low_cause_a: assert property (@(posedge ref_clk) disable iff (!resetn)
    $rose(battery_low_flag) |-> $past(conv.bat_valid) && $past(battery_low_check_on))
    else $error("battery low flag rose without a result");

  // Clear without a new crossing drops the battery high flag
  bat_clear_a: assert property (@(posedge ref_clk) disable iff (!resetn)
    flag_clear[`TLA_FLAG_BAT_HIGH] && !conv.bat_valid |=> !battery_high_flag)
    else $error("battery high flag not cleared");

  in_hold_a: assert property (@(posedge ref_clk) disable iff (!resetn)
    input_low_flag && !flag_clear[`TLA_FLAG_IN_LOW] |=> input_low_flag)
    else $error("input low flag dropped without clear");

  // Write then read of the input low limit code returns the written value
  limit_rw_a: assert property (@(posedge ref_clk) disable iff (!resetn)
    reg_req.wr && (reg_req.cmd == `TLA_CMD_IN_LOW) ##1
    (reg_req.rd && !reg_req.wr && (reg_req.cmd == `TLA_CMD_IN_LOW))
    |=> rd_ack && (rd_data == $past(reg_req.wdata, 2)))
    else $error("input limit readback mismatch");

  unmapped_read_a: assert property (@(posedge ref_clk) disable iff (!resetn)
    reg_req.rd && (reg_req.cmd > `TLA_CMD_IN_LOW) |=> rd_ack && !cmd_hit && (rd_data == 16'h0000))
    else $error("unmapped read not zero");

  total_scale_a: assert property (@(posedge ref_clk) disable iff (!resetn)
    conv.bat_valid && (cell_sync == 2'b11) && $stable(cell_sync)
    |=> battery_total == 19'($past(conv.bat) * 4))
    else $error("four cell total wrong");

endmodule : tla_alert_limits

// ===== tla_host.sv
// Host model that reaches the alert limit registers by command code
`timescale 1ns/1ps
module tla_host (
  // Clock
  input wire logic ref_clk,
  // Register port
  output tla_pkg::tla_reg_req_s reg_req,
  input wire logic [15:0] rd_data,
  input wire logic rd_ack
);
  initial reg_req = '0;

  // One-cycle strobe; the answer stands in the cycle after it
  task automatic access(input logic wr, input logic [7:0] cmd, input logic [15:0] wdata,
    output logic [15:0] rdata, output logic ack);
    @(negedge ref_clk);
    reg_req = '{wr: wr, rd: !wr, cmd: cmd, wdata: wdata};
    @(negedge ref_clk);
    rdata = rd_data;
    ack = rd_ack;
    // Released lines show the inverse, not the last value
    reg_req = '{wr: 1'b0, rd: 1'b0, cmd: ~cmd, wdata: ~wdata};
  endtask : access

  // Write strobe then read strobe on back-to-back edges; the read sees the new value
  task automatic write_read(input logic [7:0] cmd, input logic [15:0] wdata,
    output logic [15:0] rdata);
    @(negedge ref_clk);
    reg_req = '{wr: 1'b1, rd: 1'b0, cmd: cmd, wdata: wdata};
    @(negedge ref_clk);
    reg_req = '{wr: 1'b0, rd: 1'b1, cmd: cmd, wdata: ~wdata};
    @(negedge ref_clk);
    rdata = rd_data;
    reg_req = '{wr: 1'b0, rd: 1'b0, cmd: ~cmd, wdata: ~wdata};
  endtask : write_read
endmodule : tla_host

// ===== tla_alert_limits_test.sv
// Self-checking bench of the alert limit bank
`timescale 1ns/1ps
`include "tla_defs.svh"
`define TLA_CHK(got, exp) begin checks_done++; if ((got) !== (exp)) begin miscompares++; \
  $display("[FAIL] t=%0t got=%h exp=%h", $time, (got), (exp)); end end
module tla_alert_limits_test;
  logic ref_clk = 1'b0;
  logic resetn = 1'b0;
  tla_pkg::tla_reg_req_s reg_req;
  tla_pkg::tla_conv_s conv = '0;
  logic bl_on = 1'b0;
  logic bh_on = 1'b0;
  logic il_on = 1'b0;
  logic [2:0] flag_clear = '0;
  logic [1:0] cells = '0;
  logic [15:0] rd_data;
  logic rd_ack, cmd_hit, bl_f, bh_f, il_f, ack;
  logic signed [18:0] total;
  logic signed [18:0] exp_t = '0;
  logic [2:0] exp_f = '0;
  logic [15:0] rdat;
  tla_pkg::tla_value_t lim [3];
  int miscompares = 0;
  int checks_done = 0;

  tla_host i_tla_host (.ref_clk(ref_clk), .reg_req(reg_req), .rd_data(rd_data), .rd_ack(rd_ack));
  tla_alert_limits i_tla_alert_limits (.ref_clk(ref_clk), .resetn(resetn), .reg_req(reg_req),
    .rd_data(rd_data), .rd_ack(rd_ack), .cmd_hit(cmd_hit), .conv(conv),
    .battery_low_check_on(bl_on), .battery_high_check_on(bh_on), .input_low_check_on(il_on),
    .flag_clear(flag_clear), .battery_low_flag(bl_f), .battery_high_flag(bh_f),
    .input_low_flag(il_f), .cell_count_sel_lo(cells[0]), .cell_count_sel_hi(cells[1]),
    .battery_total(total));

  // Set wins over clear
  function automatic logic [2:0] next_flags(input logic [2:0] f, input logic [2:0] hit,
    input logic [2:0] clr);
    return hit | (f & ~clr);
  endfunction : next_flags

  task automatic reg_check(input logic [7:0] cmd, input logic [15:0] exp);
    i_tla_host.access(1'b0, cmd, 16'h0000, rdat, ack);
    `TLA_CHK(rdat, exp)
    `TLA_CHK(ack, 1'b1)
    `TLA_CHK(cmd_hit, 1'(cmd >= `TLA_CMD_BAT_LOW && cmd <= `TLA_CMD_IN_LOW))
  endtask : reg_check

  // Results land within two counts of each limit, so equality is hit too
  task automatic run_random(input int n);
    logic [2:0] hit;
    for (int k = 0; k < n; k++)
    begin
      @(negedge ref_clk);
      `TLA_CHK({il_f, bh_f, bl_f}, exp_f)
      `TLA_CHK(total, exp_t)
      conv.bat_valid = 1'($urandom_range(1));
      conv.in_valid = 1'($urandom_range(1));
      conv.bat = lim[$urandom_range(1)] + 16'($urandom_range(4)) - 16'h0002;
      conv.vin = lim[2] + 16'($urandom_range(4)) - 16'h0002;
      {bl_on, bh_on, il_on} = 3'($urandom());
      flag_clear = ($urandom_range(3) == 0) ? 3'($urandom()) : 3'h0;
      hit[0] = conv.bat_valid & bl_on & (conv.bat < lim[0]);
      hit[1] = conv.bat_valid & bh_on & (conv.bat > lim[1]);
      hit[2] = conv.in_valid & il_on & (conv.vin < lim[2]);
      exp_f = next_flags(exp_f, hit, flag_clear);
      if (conv.bat_valid)
        exp_t = conv.bat * (19'sh00001 + $signed({17'h00000, cells}));
    end
    @(negedge ref_clk);
    conv.bat_valid = 1'b0;
    conv.in_valid = 1'b0;
    flag_clear = 3'h0;
  endtask : run_random

  task automatic complete_run();
    if (miscompares == 0 && checks_done > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask : complete_run

  initial forever #5 ref_clk = ~ref_clk;

  initial
  begin
    #200000;
    miscompares++;
    complete_run();
  end

  initial
  begin
    void'($urandom(32'h10dd13ee));
    repeat (6) @(posedge ref_clk);
    @(negedge ref_clk);
    resetn = 1'b1;
    for (int i = 1; i <= 3; i++)
      reg_check(8'(i), `TLA_LIMIT_RESET);
    reg_check(8'h04, 16'h0000);
    // Each pass: new cell setting, new limits, then random results
    for (int s = 0; s < 4; s++)
    begin
      cells = 2'(s);
      for (int i = 0; i < 3; i++)
      begin
        lim[i] = 16'($urandom());
        if (i == 2)
        begin
          i_tla_host.write_read(8'(i + 1), lim[i], rdat);
          `TLA_CHK(rdat, lim[i])
        end
        else
        begin
          i_tla_host.access(1'b1, 8'(i + 1), lim[i], rdat, ack);
          `TLA_CHK(cmd_hit, 1'b1)
        end
        reg_check(8'(i + 1), lim[i]);
      end
      repeat (4) @(negedge ref_clk);
      run_random(200);
    end
    complete_run();
  end
endmodule : tla_alert_limits_test
